// ---- hw/srtd_consts.vh ----
`ifndef SRTD_CONSTS_VH
`define SRTD_CONSTS_VH

// register offsets (byte addresses on the plain port)
`define SRTD_ADDR_W 8
`define SRTD_OFS_X 8'h00
`define SRTD_OFS_Y 8'h01
`define SRTD_OFS_Z 8'h02
`define SRTD_OFS_TILT 8'h03
`define SRTD_OFS_RATE 8'h08
`define SRTD_OFS_MODE 8'h10

// sample rate register fields
`define SRTD_AR_LSB 0
`define SRTD_AR_MSB 2
`define SRTD_WR_LSB 3
`define SRTD_WR_MSB 4
`define SRTD_FLT_LSB 5
`define SRTD_FLT_MSB 7
`define SRTD_RATE_RST 8'h00
// per-field reset values, and the filter code that bypasses debounce
`define SRTD_AR_RST 3'h0
`define SRTD_WR_RST 2'h0
`define SRTD_FLT_RST 3'h0
`define SRTD_FLT_OFF 3'h0
// mode register: bit 0 selects auto-wake pacing
`define SRTD_MODE_AW_BIT 0
`define SRTD_MODE_RST 1'b0

// active rate codes
`define SRTD_AR_120 3'h0
`define SRTD_AR_64 3'h1
`define SRTD_AR_32 3'h2
`define SRTD_AR_16 3'h3
`define SRTD_AR_8 3'h4
`define SRTD_AR_4 3'h5
`define SRTD_AR_2 3'h6
`define SRTD_AR_1 3'h7
// wake rate codes
`define SRTD_WR_32 2'h0
`define SRTD_WR_16 2'h1
`define SRTD_WR_8 2'h2
`define SRTD_WR_1 2'h3

// sample periods in microseconds, and clock rate in MHz
`define SRTD_CLK_MHZ 25
`define SRTD_T120_US 8360
`define SRTD_T64_US 15625
`define SRTD_T32_US 31250
`define SRTD_T16_US 62500
`define SRTD_T8_US 125000
`define SRTD_T4_US 250000
`define SRTD_T2_US 500000
`define SRTD_T1_US 1000000

// measurements per averaged sample
`define SRTD_NMEAS 32
`define SRTD_NMEAS_LOG2 5
`define SRTD_AXIS_W 6

// orientation codes
`define SRTD_OR_W 3
`define SRTD_OR_UNKNOWN 3'h0
`define SRTD_OR_LEFT 3'h1
`define SRTD_OR_RIGHT 3'h2
`define SRTD_OR_DOWN 3'h5
`define SRTD_OR_UP 3'h6
// debounce count width (holds up to 8)
`define SRTD_DB_W 4
`define SRTD_DB_ONE 4'h1
`define SRTD_DB_MAX 4'h8

`endif

// ---- hw/srtd_avg.v ----
`timescale 1ns/10ps
`include "srtd_consts.vh"

// averages a burst of measurements on three axes
module srtd_avg #(
  parameter AXIS_W = `SRTD_AXIS_W,
  parameter NLOG2 = `SRTD_NMEAS_LOG2
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_clk_en,
  input wire i_start,
  input wire i_meas_valid,
  input wire [3*AXIS_W-1:0] i_meas_xyz,
  output reg o_busy,
  output reg o_done,
  output reg [3*AXIS_W-1:0] o_avg_xyz
);

  localparam SUM_W = AXIS_W + NLOG2; // room for the full sum
  localparam [NLOG2-1:0] CNT_LAST = {NLOG2{1'b1}};

  reg [NLOG2-1:0] cnt_q; // measurements taken so far
  wire last_w; // final measurement of the burst
  assign last_w = o_busy && i_meas_valid && (cnt_q == CNT_LAST);

  // burst control: count accepted measurements
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      cnt_q <= {NLOG2{1'b0}};
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else if (i_clk_en) begin
      o_done <= last_w;
      if (i_start && !o_busy) begin
        o_busy <= 1'b1;
        cnt_q <= {NLOG2{1'b0}};
      end else if (o_busy && i_meas_valid) begin
        cnt_q <= cnt_q + 1'b1;
        if (last_w) begin
          o_busy <= 1'b0;
        end
      end
    end
  end

  // one accumulator per axis
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_axis
      reg signed [SUM_W-1:0] sum_q; // running sum
      wire signed [AXIS_W-1:0] in_w; // this axis' measurement
      wire signed [SUM_W-1:0] nxt_w; // sum with current measurement
      assign in_w = i_meas_xyz[g*AXIS_W +: AXIS_W];
      assign nxt_w = sum_q + {{NLOG2{in_w[AXIS_W-1]}}, in_w};
      always @(posedge i_sys_clk) begin
        if (i_rst) begin
          sum_q <= {SUM_W{1'b0}};
          o_avg_xyz[g*AXIS_W +: AXIS_W] <= {AXIS_W{1'b0}};
        end else if (i_clk_en) begin
          if (i_start && !o_busy) begin
            sum_q <= {SUM_W{1'b0}};
          end else if (o_busy && i_meas_valid) begin
            sum_q <= nxt_w;
            if (last_w) begin
              // divide by the burst length
              o_avg_xyz[g*AXIS_W +: AXIS_W] <= nxt_w[SUM_W-1:NLOG2];
            end
          end
        end
      end
    end
  endgenerate

endmodule // srtd_avg

// ---- hw/srtd_top.v ----
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/10ps
`include "srtd_consts.vh"

module srtd_top #(
  parameter PER_W = 25,
  parameter [PER_W-1:0] P_CYC_120 = `SRTD_T120_US * `SRTD_CLK_MHZ,
  parameter [PER_W-1:0] P_CYC_64 = `SRTD_T64_US * `SRTD_CLK_MHZ,
  parameter [PER_W-1:0] P_CYC_32 = `SRTD_T32_US * `SRTD_CLK_MHZ,
  parameter [PER_W-1:0] P_CYC_16 = `SRTD_T16_US * `SRTD_CLK_MHZ,
  parameter [PER_W-1:0] P_CYC_8 = `SRTD_T8_US * `SRTD_CLK_MHZ,
  parameter [PER_W-1:0] P_CYC_4 = `SRTD_T4_US * `SRTD_CLK_MHZ,
  parameter [PER_W-1:0] P_CYC_2 = `SRTD_T2_US * `SRTD_CLK_MHZ,
  parameter [PER_W-1:0] P_CYC_1 = `SRTD_T1_US * `SRTD_CLK_MHZ
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_clk_en,
  input wire [`SRTD_ADDR_W-1:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire i_meas_valid,
  input wire [`SRTD_AXIS_W-1:0] i_meas_x,
  input wire [`SRTD_AXIS_W-1:0] i_meas_y,
  input wire [`SRTD_AXIS_W-1:0] i_meas_z,
  output reg [7:0] o_rdata,
  output reg o_meas_req,
  output reg o_sample_stb
);

  localparam AW = `SRTD_AXIS_W; // axis width
  localparam ORW = `SRTD_OR_W; // orientation width
  localparam DBW = `SRTD_DB_W; // debounce counter width

  // pacing states
  localparam [1:0] ST_WAIT = 2'h0;
  localparam [1:0] ST_MEAS = 2'h1;
  localparam [1:0] ST_POST = 2'h2;

  // software settings
  reg [2:0] active_rate_sel_q; // active / auto-sleep rate code
  reg [1:0] wake_rate_sel_q; // auto-wake rate code
  reg [2:0] orient_debounce_cnt_q; // filter depth code
  reg auto_wake_q; // pacing follows the wake rate when set

  // sample results
  reg [AW-1:0] x_axis_result_q; // averaged x
  reg [AW-1:0] y_axis_result_q; // averaged y
  reg [AW-1:0] z_axis_result_q; // averaged z
  reg [ORW-1:0] tilt_q; // committed orientation
  reg [ORW-1:0] cand_q; // candidate orientation
  reg [DBW-1:0] match_q; // consecutive agreeing samples

  // pacing
  reg [PER_W-1:0] per_cnt_q; // cycles left in this period
  reg [1:0] state_q; // pacing state
  reg [1:0] state_d; // next pacing state
  reg start_q; // starts an averaging burst

  // averager link
  wire avg_busy_w; // burst in progress
  wire avg_done_w; // burst finished, average valid in the same cycle
  wire [3*AW-1:0] avg_xyz_w; // averaged axes, x in low bits
  wire tick_w; // period boundary
  wire [PER_W-1:0] per_sel_w; // period length for current settings
  wire [ORW-1:0] orient_w; // orientation of the new sample
  wire [DBW-1:0] match_n_w; // run length including the new sample
  wire [DBW-1:0] need_w; // run length required to commit

  // period length for the active-mode rate code
  function [PER_W-1:0] active_period;
    input [2:0] code;
    begin
      case (code)
        `SRTD_AR_120: active_period = P_CYC_120;
        `SRTD_AR_64: active_period = P_CYC_64;
        `SRTD_AR_32: active_period = P_CYC_32;
        `SRTD_AR_16: active_period = P_CYC_16;
        `SRTD_AR_8: active_period = P_CYC_8;
        `SRTD_AR_4: active_period = P_CYC_4;
        `SRTD_AR_2: active_period = P_CYC_2;
        default: active_period = P_CYC_1;
      endcase
    end
  endfunction

  // period length for the auto-wake rate code
  function [PER_W-1:0] wake_period;
    input [1:0] code;
    begin
      case (code)
        `SRTD_WR_32: wake_period = P_CYC_32;
        `SRTD_WR_16: wake_period = P_CYC_16;
        `SRTD_WR_8: wake_period = P_CYC_8;
        default: wake_period = P_CYC_1;
      endcase
    end
  endfunction

  // portrait / landscape from the dominant of x and y
  function [ORW-1:0] orient_of;
    input [AW-1:0] x;
    input [AW-1:0] y;
    reg [AW-1:0] ax;
    reg [AW-1:0] ay;
    begin
      ax = x[AW-1] ? (~x + 1'b1) : x;
      ay = y[AW-1] ? (~y + 1'b1) : y;
      if (ax > ay) begin
        orient_of = x[AW-1] ? `SRTD_OR_RIGHT : `SRTD_OR_LEFT;
      end else if (ay > ax) begin
        orient_of = y[AW-1] ? `SRTD_OR_UP : `SRTD_OR_DOWN;
      end else begin
        orient_of = `SRTD_OR_UNKNOWN;
      end
    end
  endfunction

  // mode picks which rate field paces sampling
  assign per_sel_w = auto_wake_q ? wake_period(wake_rate_sel_q)
                                 : active_period(active_rate_sel_q);
  assign tick_w = (per_cnt_q == {PER_W{1'b0}});
  assign orient_w = orient_of(avg_xyz_w[0 +: AW], avg_xyz_w[AW +: AW]);
  // a new sample either extends the run or opens a new one
  assign match_n_w = (orient_w != cand_q) ? `SRTD_DB_ONE
                   : ((match_q == `SRTD_DB_MAX) ? match_q : match_q + 1'b1);
  assign need_w = {1'b0, orient_debounce_cnt_q} + 1'b1;

  // averaging of the measurement burst
  srtd_avg #(
    .AXIS_W(AW),
    .NLOG2(`SRTD_NMEAS_LOG2)
  ) u_avg (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_clk_en(i_clk_en),
    .i_start(start_q),
    .i_meas_valid(i_meas_valid),
    .i_meas_xyz({i_meas_z, i_meas_y, i_meas_x}),
    .o_busy(avg_busy_w),
    .o_done(avg_done_w),
    .o_avg_xyz(avg_xyz_w)
  );

  // register writes
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      active_rate_sel_q <= `SRTD_AR_RST;
      wake_rate_sel_q <= `SRTD_WR_RST;
      orient_debounce_cnt_q <= `SRTD_FLT_RST;
      auto_wake_q <= `SRTD_MODE_RST;
    end else if (i_clk_en && i_wr) begin
      if (i_addr == `SRTD_OFS_RATE) begin
        active_rate_sel_q <= i_wdata[`SRTD_AR_MSB:`SRTD_AR_LSB];
        wake_rate_sel_q <= i_wdata[`SRTD_WR_MSB:`SRTD_WR_LSB];
        orient_debounce_cnt_q <= i_wdata[`SRTD_FLT_MSB:`SRTD_FLT_LSB];
      end else if (i_addr == `SRTD_OFS_MODE) begin
        auto_wake_q <= i_wdata[`SRTD_MODE_AW_BIT];
      end
    end
  end

  // register reads, data in the following cycle only
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_clk_en) begin
      if (!i_rd) begin
        o_rdata <= 8'h00;
      end else if (i_addr == `SRTD_OFS_X) begin
        o_rdata <= {{(8-AW){1'b0}}, x_axis_result_q};
      end else if (i_addr == `SRTD_OFS_Y) begin
        o_rdata <= {{(8-AW){1'b0}}, y_axis_result_q};
      end else if (i_addr == `SRTD_OFS_Z) begin
        o_rdata <= {{(8-AW){1'b0}}, z_axis_result_q};
      end else if (i_addr == `SRTD_OFS_TILT) begin
        o_rdata <= {{(8-ORW){1'b0}}, tilt_q};
      end else if (i_addr == `SRTD_OFS_RATE) begin
        o_rdata <= {orient_debounce_cnt_q, wake_rate_sel_q, active_rate_sel_q};
      end else if (i_addr == `SRTD_OFS_MODE) begin
        o_rdata <= {7'h00, auto_wake_q};
      end else begin
        // unmapped reads return zero
        o_rdata <= 8'h00;
      end
    end
  end

  // period counter, reloaded from the live settings at each boundary
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      per_cnt_q <= {PER_W{1'b0}};
    end else if (i_clk_en) begin
      if (tick_w) begin
        per_cnt_q <= per_sel_w - 1'b1;
      end else begin
        per_cnt_q <= per_cnt_q - 1'b1;
      end
    end
  end

  // pacing state machine, next state
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_WAIT: begin
        if (tick_w) begin
          state_d = ST_MEAS;
        end
      end
      ST_MEAS: begin
        if (avg_done_w) begin
          state_d = ST_POST;
        end
      end
      ST_POST: begin
        state_d = ST_WAIT;
      end
      default: begin
        state_d = ST_WAIT;
      end
    endcase
  end

  // pacing state machine, burst request to the sensing cell
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_q <= ST_WAIT;
      start_q <= 1'b0;
      o_meas_req <= 1'b0;
    end else if (i_clk_en) begin
      state_q <= state_d;
      start_q <= (state_q == ST_WAIT) && tick_w && !avg_busy_w;
      // request stays high from burst start until the averager reports the burst done
      if ((state_q == ST_WAIT) && tick_w) begin
        o_meas_req <= 1'b1;
      end else if (avg_done_w || (state_q != ST_MEAS)) begin
        o_meas_req <= 1'b0;
      end
    end
  end

  // axis results are replaced whole, only when a sample completes
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      x_axis_result_q <= {AW{1'b0}};
      y_axis_result_q <= {AW{1'b0}};
      z_axis_result_q <= {AW{1'b0}};
      o_sample_stb <= 1'b0;
    end else if (i_clk_en) begin
      o_sample_stb <= (state_q == ST_POST);
      if (state_q == ST_POST) begin
        x_axis_result_q <= avg_xyz_w[0 +: AW];
        y_axis_result_q <= avg_xyz_w[AW +: AW];
        z_axis_result_q <= avg_xyz_w[2*AW +: AW];
      end
    end
  end

  // orientation debounce, one step per completed sample
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      tilt_q <= `SRTD_OR_UNKNOWN;
      cand_q <= `SRTD_OR_UNKNOWN;
      match_q <= {DBW{1'b0}};
    end else if (i_clk_en && (state_q == ST_POST)) begin
      cand_q <= orient_w;
      match_q <= match_n_w;
      if (orient_debounce_cnt_q == `SRTD_FLT_OFF) begin
        // filter off: follow every sample
        tilt_q <= orient_w;
      end else if (match_n_w >= need_w) begin
        // run long enough: commit the candidate
        tilt_q <= orient_w;
      end
    end
  end

endmodule // srtd_top

// ---- testbench/srtd_props.sv ----
`timescale 1ns/10ps
`include "srtd_consts.vh"

// port-level checker for bus and measurement burst timing
module srtd_props (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_clk_en,
  input wire [`SRTD_ADDR_W-1:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire i_meas_valid,
  input wire [7:0] o_rdata,
  input wire o_meas_req,
  input wire o_sample_stb
);
  reg [7:0] rate_q; // shadow of rate register
  reg mode_q; // shadow of auto-wake bit
  reg [6:0] nval_q; // valids taken in the running burst
  default clocking cb @(posedge i_sys_clk); endclocking
  // frozen cycles hold every output, so nothing is judged while the enable is low
  default disable iff (i_rst || !i_clk_en);
  // shadow writes, count valids while a burst is wanted
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      rate_q <= 8'h00;
      mode_q <= 1'b0;
      nval_q <= 7'h00;
    end else if (i_clk_en) begin
      if (i_wr && i_addr == `SRTD_OFS_RATE) rate_q <= i_wdata;
      if (i_wr && i_addr == `SRTD_OFS_MODE) mode_q <= i_wdata[0];
      // saturate at a full burst: valids after the last one are not taken
      nval_q <= o_meas_req ? nval_q + {6'h00, i_meas_valid && (nval_q < 7'h20)} : 7'h00;
    end
  end
  property p_rd_idle;
    !$past(i_rd) |-> o_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  property p_rate_rb;
    $past(i_rd && i_addr == `SRTD_OFS_RATE) |-> o_rdata == rate_q;
  endproperty
  a_rate_rb: assert property (p_rate_rb) else $error("rate readback wrong");
  property p_mode_rb;
    $past(i_rd && i_addr == `SRTD_OFS_MODE) |-> o_rdata == {7'h00, mode_q};
  endproperty
  a_mode_rb: assert property (p_mode_rb) else $error("mode readback wrong");
  property p_stb_pulse;
    o_sample_stb |=> !o_sample_stb;
  endproperty
  a_stb_pulse: assert property (p_stb_pulse) else $error("strobe too long");
  property p_fall_stb;
    $fell(o_meas_req) |=> o_sample_stb;
  endproperty
  a_fall_stb: assert property (p_fall_stb) else $error("no strobe after burst");
  property p_stb_cause;
    o_sample_stb |-> $past(o_meas_req, 2) && !$past(o_meas_req);
  endproperty
  a_stb_cause: assert property (p_stb_cause) else $error("strobe without burst");
  property p_burst_len;
    $fell(o_meas_req) |-> nval_q == 7'h20;
  endproperty
  a_burst_len: assert property (p_burst_len) else $error("burst not 32 long");
  property p_req_hold;
    o_meas_req && (nval_q + {6'h00, i_meas_valid}) < 7'h20 |=> o_meas_req;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("burst ended early");
  // request drops the cycle after the 32nd measurement is counted
  property p_req_end;
    o_meas_req && nval_q == 7'h20 |=> !o_meas_req;
  endproperty
  a_req_end: assert property (p_req_end) else $error("burst did not end");
  c_stb: cover property (o_sample_stb);
  c_fall: cover property ($fell(o_meas_req));
  c_rate_rd: cover property ($past(i_rd && i_addr == `SRTD_OFS_RATE) && o_rdata != 8'h00);
endmodule // srtd_props

bind srtd_top srtd_props u_srtd_props (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
  .i_clk_en(i_clk_en), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_meas_valid(i_meas_valid),
  .o_rdata(o_rdata), .o_meas_req(o_meas_req), .o_sample_stb(o_sample_stb));

// ---- testbench/sample_rate_and_tilt_debounce_tb.sv ----
`timescale 1ns/10ps
`include "srtd_consts.vh"

// bench for sample pacing, averaging and tilt debounce
module sample_rate_and_tilt_debounce_tb;
  localparam int PER [12] = '{100, 120, 140, 160, 180, 200, 220, 240, 140, 160, 180, 240};
  localparam logic [5:0] DX [10] = '{6'h0A, 6'h14, 6'h2C, 0, 0, 0, 6'h14, 0, 0, 0};
  localparam logic [5:0] DY [10] = '{6'h0A, 0, 0, 6'h2C, 6'h14, 6'h14, 0, 6'h14, 6'h14, 6'h14};
  localparam logic [7:0] DT [10] = '{0, 1, 2, 6, 6, 6, 6, 6, 6, 5};
  reg clk = 1'b0; // 25 MHz clock
  reg rst = 1'b1; // synchronous reset
  reg ce = 1'b1; // clock enable, dropped once to freeze the block
  reg wr = 1'b0, rd = 1'b0, mv = 1'b0, alt = 1'b0;
  reg [7:0] addr = 8'h00, wdata = 8'h00, d;
  reg [5:0] vx = 0, vy = 0, vz = 0, mx = 0, my = 0, mz = 0; // wanted and driven values
  integer n_fail = 0, num_checks = 0, cyc = 0, t0 = 0, t1 = 0, i;
  wire [7:0] rdata;
  wire req, stb;
  // short periods taken from the row table, so expectations share one source
  srtd_top #(.P_CYC_120(25'(PER[0])), .P_CYC_64(25'(PER[1])), .P_CYC_32(25'(PER[2])),
    .P_CYC_16(25'(PER[3])), .P_CYC_8(25'(PER[4])), .P_CYC_4(25'(PER[5])),
    .P_CYC_2(25'(PER[6])), .P_CYC_1(25'(PER[7]))) u_srtd_top (.i_sys_clk(clk),
    .i_rst(rst), .i_clk_en(ce),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_meas_valid(mv),
    .i_meas_x(mx), .i_meas_y(my), .i_meas_z(mz), .o_rdata(rdata), .o_meas_req(req),
    .o_sample_stb(stb));
  always #20 clk = ~clk;
  // sensing cell: answers each wanted burst, values alternate v and v+1
  always @(posedge clk) begin
    cyc <= cyc + 1;
    alt <= ~alt;
    mv <= req;
    mx <= vx + {5'h00, alt};
    my <= vy + {5'h00, alt};
    mz <= vz + {5'h00, alt};
  end
  task chk(input [7:0] seen, input [7:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task wr_reg(input [7:0] a, input [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // bounded wait for a sample strobe, keeps its cycle stamp
  task wait_stb;
    integer k;
    k = 0;
    @(posedge clk);
    #1;
    while (stb !== 1'b1 && k < 2000) begin
      @(posedge clk);
      #1;
      k = k + 1;
    end
    if (k == 2000) chk(8'h01, 8'h00);
    t0 = t1;
    t1 = cyc;
  endtask
  task print_verdict;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // watchdog against a hung run
  initial begin
    repeat (40000) @(posedge clk);
    n_fail = n_fail + 1;
    print_verdict;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd_reg(`SRTD_OFS_RATE); chk(d, `SRTD_RATE_RST);
    rd_reg(`SRTD_OFS_TILT); chk(d, 8'h00);
    wr_reg(`SRTD_OFS_MODE, 8'hFF);
    rd_reg(`SRTD_OFS_MODE); chk(d, 8'h01);
    wr_reg(8'h05, 8'hFF);
    rd_reg(8'h05); chk(d, 8'h00);
    // rows: active codes then wake codes, each with its period
    for (i = 0; i < 12; i = i + 1) begin
      wr_reg(`SRTD_OFS_RATE, i < 8 ? 8'(i) : 8'((i - 8) << 3));
      wr_reg(`SRTD_OFS_MODE, i < 8 ? 8'h00 : 8'h01);
      rd_reg(`SRTD_OFS_X);
      if (i > 0) chk(d, {2'h0, vx});
      vx = 6'(i) - 6'h06;
      vz = 6'(i);
      repeat (3) wait_stb;
      chk(8'(t1 - t0), 8'(PER[i]));
      rd_reg(`SRTD_OFS_X); chk(d, {2'h0, vx});
      rd_reg(`SRTD_OFS_Z); chk(d, {2'h0, vz});
    end
    // debounce: bypass first, then three agreeing samples needed
    wr_reg(`SRTD_OFS_MODE, 8'h00);
    wr_reg(`SRTD_OFS_RATE, 8'h00);
    wait_stb;
    for (i = 0; i < 10; i = i + 1) begin
      if (i == 4) wr_reg(`SRTD_OFS_RATE, 8'h40);
      vx = DX[i];
      vy = DY[i];
      wait_stb;
      rd_reg(`SRTD_OFS_TILT); chk(d, DT[i]);
      rd_reg(`SRTD_OFS_Y); chk(d, {2'h0, vy});
    end
    // enable low for 20 edges right after a strobe stretches that period by 20
    wait_stb;
    @(posedge clk);
    ce <= 1'b0;
    repeat (20) @(posedge clk);
    ce <= 1'b1;
    wait_stb;
    chk(8'(t1 - t0), 8'(PER[0] + 20));
    rd_reg(`SRTD_OFS_TILT); chk(d, DT[9]);
    // second reset in mid-run clears the settings
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_reg(`SRTD_OFS_RATE); chk(d, 8'h00);
    print_verdict;
  end
endmodule // sample_rate_and_tilt_debounce_tb
